// ===== verilog/eaisr_regs.sv
// external area interface select registers and decoded per-area settings
//
// The register addresses and strobed register access were chosen for this implementation.
`timescale 1ns/10ps

module eaisr_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [15:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rd_data,
  input wire logic [7:0] area_8bit,
  input wire logic [7:0] area_muxed_sel,
  input wire logic ext_bus_busy,
  output logic [15:0] area_if_type,
  output logic [3:0] area0_burst_cycles,
  output logic [5:0] area0_burst_words,
  output logic [3:0] area1_burst_cycles,
  output logic [5:0] area1_burst_words,
  output logic cfg_pending
);

  // ==========================================================
  // software registers
  logic [15:0] sram_mode_select;
  logic [15:0] burst_rom_control;
  logic sram_hit;
  logic rom_hit;

  assign sram_hit = addr == eaisr_pkg::SRAM_MODE_OFS;
  assign rom_hit = addr == eaisr_pkg::BURST_ROM_OFS;

  // masked write keeps reserved bits at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sram_mode_select <= eaisr_pkg::SRAM_MODE_RST;
    end else if (ce && wr_stb && sram_hit) begin
      sram_mode_select <= wr_data & eaisr_pkg::SRAM_MODE_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      burst_rom_control <= eaisr_pkg::BURST_ROM_RST;
    end else if (ce && wr_stb && rom_hit) begin
      burst_rom_control <= wr_data & eaisr_pkg::BURST_ROM_WMASK;
    end
  end

  // ==========================================================
  // live decode of every area
  logic [7:0] byte_sel;
  logic [7:0] rom_sel;
  logic [7:0] muxed_sel;
  logic [15:0] live_if_type;
  logic [7:0] live_is_byte;

  assign byte_sel = sram_mode_select[eaisr_pkg::BYTE_SEL_LSB +: 8];

  // only areas 0 and 1 have a burst ROM mode; only 7..3 can be muxed
  assign rom_sel = {6'h00, burst_rom_control[eaisr_pkg::A1_ROM_BIT],
                    burst_rom_control[eaisr_pkg::A0_ROM_BIT]};
  assign muxed_sel = {area_muxed_sel[7:3], 3'h0};

  for (genvar i = 0; i < eaisr_pkg::NUM_AREAS; i++) begin : g_area
    eaisr_pkg::eaisr_if_type t;
    eaisr_area_decode u_dec (
      .byte_sel(byte_sel[i]),
      .rom_sel(rom_sel[i]),
      .muxed_sel(muxed_sel[i]),
      .width_8bit(area_8bit[i]),
      .if_type(t)
    );
    assign live_if_type[2*i +: 2] = t;
    assign live_is_byte[i] = t == eaisr_pkg::EAISR_IF_BYTE;
  end

  logic [3:0] live_a0_cycles;
  logic [5:0] live_a0_words;
  logic [3:0] live_a1_cycles;
  logic [5:0] live_a1_words;

  eaisr_burst_decode u_burst0 (
    .len_code(burst_rom_control[eaisr_pkg::A0_LEN_LSB +: 3]),
    .words_code(burst_rom_control[eaisr_pkg::A0_WORDS_LSB +: 2]),
    .burst_cycles(live_a0_cycles),
    .burst_words(live_a0_words)
  );

  eaisr_burst_decode u_burst1 (
    .len_code(burst_rom_control[eaisr_pkg::A1_LEN_LSB +: 3]),
    .words_code(burst_rom_control[eaisr_pkg::A1_WORDS_LSB +: 2]),
    .burst_cycles(live_a1_cycles),
    .burst_words(live_a1_words)
  );

  // ==========================================================
  // apply control
  // settings change only while the external bus is idle, so an access in
  // flight never sees its interface type switch under it
  eaisr_pkg::eaisr_apply_type state;
  eaisr_pkg::eaisr_apply_type next_state;
  logic mismatch;
  logic load_cfg;

  assign mismatch = live_if_type != area_if_type ||
                    live_a0_cycles != area0_burst_cycles ||
                    live_a0_words != area0_burst_words ||
                    live_a1_cycles != area1_burst_cycles ||
                    live_a1_words != area1_burst_words;

  assign load_cfg = ce && state == eaisr_pkg::EAISR_APPLY_PENDING && !ext_bus_busy;

  always_comb begin
    case (state)
      eaisr_pkg::EAISR_APPLY_SYNCED: begin
        next_state = mismatch ? eaisr_pkg::EAISR_APPLY_PENDING
                              : eaisr_pkg::EAISR_APPLY_SYNCED;
      end
      eaisr_pkg::EAISR_APPLY_PENDING: begin
        next_state = ext_bus_busy ? eaisr_pkg::EAISR_APPLY_PENDING
                                  : eaisr_pkg::EAISR_APPLY_SYNCED;
      end
      default: begin
        next_state = eaisr_pkg::EAISR_APPLY_SYNCED;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= eaisr_pkg::EAISR_APPLY_SYNCED;
    end else if (ce) begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_pending <= 1'b0;
    end else if (ce) begin
      cfg_pending <= next_state == eaisr_pkg::EAISR_APPLY_PENDING;
    end
  end

  // reset decodes: every area basic, one cycle, four words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      area_if_type <= 16'h0000;
      area0_burst_cycles <= eaisr_pkg::BURST_CYCLE_BASE;
      area0_burst_words <= eaisr_pkg::BURST_WORDS_BASE;
      area1_burst_cycles <= eaisr_pkg::BURST_CYCLE_BASE;
      area1_burst_words <= eaisr_pkg::BURST_WORDS_BASE;
    end else if (load_cfg) begin
      area_if_type <= live_if_type;
      area0_burst_cycles <= live_a0_cycles;
      area0_burst_words <= live_a0_words;
      area1_burst_cycles <= live_a1_cycles;
      area1_burst_words <= live_a1_words;
    end
  end

  // ==========================================================
  // read port
  logic [15:0] next_rd_data;

  always_comb begin
    next_rd_data = 16'h0000;
    if (rd_stb) begin
      case (addr)
        eaisr_pkg::SRAM_MODE_OFS: next_rd_data = sram_mode_select;
        eaisr_pkg::BURST_ROM_OFS: next_rd_data = burst_rom_control;
        eaisr_pkg::IF_STATUS_OFS: next_rd_data = area_if_type;
        default: next_rd_data = 16'h0000;
      endcase
    end
  end

  // data stand for exactly one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 16'h0000;
    end else if (ce) begin
      rd_data <= next_rd_data;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sram_low_zero_a: assert property (sram_mode_select[7:0] == 8'h00)
    else $error("sram mode low byte not zero");

  rom_resv_zero_a: assert property (
    burst_rom_control[11:10] == 2'h0 && burst_rom_control[3:2] == 2'h0)
    else $error("burst rom reserved bits not zero");

  byte_sel_write_a: assert property (
    ce && wr_stb && sram_hit |=> sram_mode_select[15:8] == $past(wr_data[15:8]))
    else $error("byte select write lost");

  width8_block_a: assert property (!(|(live_is_byte & area_8bit)))
    else $error("byte control on 8-bit area");

  area0_rom_a: assert property (
    load_cfg && burst_rom_control[15] |=> area_if_type[1:0] == 2'b10)
    else $error("area 0 not burst rom");

  area0_len_a: assert property (
    load_cfg |=> area0_burst_cycles == {1'b0, $past(burst_rom_control[14:12])} + 4'h1)
    else $error("area 0 burst cycles wrong");

  area0_words_a: assert property (
    load_cfg |=> area0_burst_words == 6'h04 << $past(burst_rom_control[9:8]))
    else $error("area 0 burst words wrong");

  area1_rom_a: assert property (
    load_cfg && burst_rom_control[7] |=> area_if_type[3:2] == 2'b10)
    else $error("area 1 not burst rom");

  area1_len_a: assert property (
    load_cfg |=> area1_burst_cycles == {1'b0, $past(burst_rom_control[6:4])} + 4'h1)
    else $error("area 1 burst cycles wrong");

  area1_words_a: assert property (
    load_cfg |=> area1_burst_words == 6'h04 << $past(burst_rom_control[1:0]))
    else $error("area 1 burst words wrong");

  busy_hold_a: assert property (
    ce && ext_bus_busy |=> $stable(area_if_type) && $stable(area0_burst_cycles))
    else $error("settings changed while bus busy");

  write_apply_a: assert property (
    ce && wr_stb && rom_hit && !ext_bus_busy ##1 ce && !ext_bus_busy [*2]
    |=> area0_burst_cycles == {1'b0, $past(burst_rom_control[14:12], 2)} + 4'h1)
    else $error("write not applied on idle bus");

  muxed_prec_a: assert property (
    load_cfg && area_muxed_sel[3] |=> area_if_type[7:6] == 2'b11)
    else $error("muxed select lost precedence");

  byte_prec_a: assert property (
    load_cfg && burst_rom_control[15] && byte_sel[0] |=> area_if_type[1:0] == 2'b10)
    else $error("byte select beat burst rom");

  byte_select_a: assert property (
    load_cfg && byte_sel[2] && !area_8bit[2] |=> area_if_type[5:4] == 2'b01)
    else $error("byte control not applied");

  width8_basic_a: assert property (
    load_cfg && area_8bit[2] |=> area_if_type[5:4] == 2'b00)
    else $error("8-bit area not basic");

  area0_basic_a: assert property (
    load_cfg && !burst_rom_control[15] && !byte_sel[0] |=> area_if_type[1:0] == 2'b00)
    else $error("area 0 not basic");

  area1_basic_a: assert property (
    load_cfg && !burst_rom_control[7] && !byte_sel[1] |=> area_if_type[3:2] == 2'b00)
    else $error("area 1 not basic");

  // areas 0 to 2 have no muxed mode at all, whatever the pins say
  low_muxed_a: assert property (
    load_cfg |=> area_if_type[1:0] != 2'b11 && area_if_type[3:2] != 2'b11 &&
                 area_if_type[5:4] != 2'b11)
    else $error("muxed type on low area");

  // ==========================================================
  // register bus checks
  rom_write_a: assert property (
    ce && wr_stb && rom_hit |=>
    burst_rom_control == ($past(wr_data) & eaisr_pkg::BURST_ROM_WMASK))
    else $error("burst rom write wrong");

  rd_sram_data_a: assert property (
    ce && rd_stb && sram_hit |=> rd_data == $past(sram_mode_select))
    else $error("sram mode read wrong");

  rd_sram_low_a: assert property (
    ce && rd_stb && sram_hit |=> rd_data[7:0] == 8'h00)
    else $error("sram mode low byte read not zero");

  rd_rom_data_a: assert property (
    ce && rd_stb && rom_hit |=> rd_data == $past(burst_rom_control))
    else $error("burst rom read wrong");

  rd_rom_resv_a: assert property (
    ce && rd_stb && rom_hit |=> rd_data[11:10] == 2'h0 && rd_data[3:2] == 2'h0)
    else $error("burst rom reserved read not zero");

  rd_status_a: assert property (
    ce && rd_stb && addr == eaisr_pkg::IF_STATUS_OFS |=> rd_data == $past(area_if_type))
    else $error("status read wrong");

  // a frozen block must not drift, or software sees half-applied settings
  ce_freeze_a: assert property (
    !ce |=> $stable(sram_mode_select) && $stable(burst_rom_control) &&
            $stable(rd_data) && $stable(area_if_type) && $stable(cfg_pending))
    else $error("state moved while clock enable low");

  // ==========================================================
  // apply checks
  pending_flag_a: assert property (
    cfg_pending == (state == eaisr_pkg::EAISR_APPLY_PENDING))
    else $error("pending flag disagrees with state");

  pending_set_a: assert property (
    ce && state == eaisr_pkg::EAISR_APPLY_SYNCED && mismatch |=> cfg_pending)
    else $error("pending not raised on change");

  idle_load_a: assert property (
    ce && cfg_pending && !ext_bus_busy |=> !cfg_pending)
    else $error("idle bus did not apply settings");

  busy_wait_a: assert property (
    ce && cfg_pending && ext_bus_busy |=> cfg_pending)
    else $error("pending dropped while bus busy");

  busy_hold_rest_a: assert property (
    ce && ext_bus_busy |=> $stable(area0_burst_words) && $stable(area1_burst_cycles) &&
                           $stable(area1_burst_words))
    else $error("burst settings changed while bus busy");

  sync_no_load_a: assert property (
    state == eaisr_pkg::EAISR_APPLY_SYNCED |=> $stable(area_if_type))
    else $error("settings changed without pending");

  sram_write_c: cover property (ce && wr_stb && sram_hit ##1 sram_mode_select != 16'h0000);
  rom_apply_c: cover property (load_cfg && burst_rom_control[15]);
  busy_wait_c: cover property (cfg_pending && ext_bus_busy ##1 cfg_pending);
  read_back_c: cover property (ce && rd_stb && addr == 4'h4 ##1 rd_data != 16'h0000);
  byte_prec_c: cover property (load_cfg && burst_rom_control[15] && byte_sel[0]);

endmodule : eaisr_regs

// ===== verilog/eaisr_pkg.sv
// constants and types shared by the external area interface select block
package eaisr_pkg;

  // ==========================================================
  // register bus
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [3:0] SRAM_MODE_OFS = 4'h0;
  localparam logic [3:0] BURST_ROM_OFS = 4'h2;
  localparam logic [3:0] IF_STATUS_OFS = 4'h4;

  localparam logic [15:0] SRAM_MODE_RST = 16'h0000;
  localparam logic [15:0] BURST_ROM_RST = 16'h0000;

  // writable bits; everything else reads zero
  localparam logic [15:0] SRAM_MODE_WMASK = 16'hFF00;
  localparam logic [15:0] BURST_ROM_WMASK = 16'hF3F3;

  // ==========================================================
  // field positions
  localparam int unsigned BYTE_SEL_LSB = 8;
  localparam int unsigned A0_ROM_BIT = 15;
  localparam int unsigned A0_LEN_LSB = 12;
  localparam int unsigned A0_WORDS_LSB = 8;
  localparam int unsigned A1_ROM_BIT = 7;
  localparam int unsigned A1_LEN_LSB = 4;
  localparam int unsigned A1_WORDS_LSB = 0;

  localparam int unsigned NUM_AREAS = 8;
  localparam int unsigned FIRST_MUXED_AREA = 3;

  // ==========================================================
  // decoded values
  localparam logic [5:0] BURST_WORDS_BASE = 6'h04;
  localparam logic [3:0] BURST_CYCLE_BASE = 4'h1;

  typedef enum logic [1:0] {
    EAISR_IF_BASIC = 2'b00,
    EAISR_IF_BYTE = 2'b01,
    EAISR_IF_ROM = 2'b10,
    EAISR_IF_MUXED = 2'b11
  } eaisr_if_type;

  typedef enum logic [0:0] {
    EAISR_APPLY_SYNCED = 1'b0,
    EAISR_APPLY_PENDING = 1'b1
  } eaisr_apply_type;

endpackage : eaisr_pkg

// ===== verilog/eaisr_area_decode.sv
// per-area interface type decode with fixed precedence
`timescale 1ns/10ps
module eaisr_area_decode (
  input wire logic byte_sel,
  input wire logic rom_sel,
  input wire logic muxed_sel,
  input wire logic width_8bit,
  output eaisr_pkg::eaisr_if_type if_type
);

  always_comb begin
    if (rom_sel) begin
      if_type = eaisr_pkg::EAISR_IF_ROM;
    end else if (muxed_sel) begin
      if_type = eaisr_pkg::EAISR_IF_MUXED;
    end else if (byte_sel && !width_8bit) begin
      if_type = eaisr_pkg::EAISR_IF_BYTE;
    end else begin
      if_type = eaisr_pkg::EAISR_IF_BASIC;
    end
  end

endmodule : eaisr_area_decode

// ===== verilog/eaisr_burst_decode.sv
// burst cycle length and word limit decode for one burst-capable area
`timescale 1ns/10ps
module eaisr_burst_decode (
  input wire logic [2:0] len_code,
  input wire logic [1:0] words_code,
  output logic [3:0] burst_cycles,
  output logic [5:0] burst_words
);

  // code plus one: 000 is one cycle, 111 is eight
  assign burst_cycles = {1'b0, len_code} + eaisr_pkg::BURST_CYCLE_BASE;

  // 4, 8, 16 or 32 words
  assign burst_words = eaisr_pkg::BURST_WORDS_BASE << words_code;

endmodule : eaisr_burst_decode

// ===== tb/eaisr_seq_model.sv
// external bus sequencer model that drives the busy flag back into the block
`timescale 1ns/10ps
module eaisr_seq_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic stall,
  input wire logic [3:0] cycles,
  output logic ext_bus_busy
);
  // ==========================================================
  // one access per start, as long as the applied burst length
  logic [3:0] left;

  // length is latched at start so a reload mid-access cannot stretch it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      left <= 4'h0;
    end else if (start && left == 4'h0) begin
      left <= cycles;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end

  // stall models a slow device that keeps the bus for as long as asked
  assign ext_bus_busy = stall || (left != 4'h0);
endmodule : eaisr_seq_model

// ===== tb/testbench.sv
// self-checking bench for the area interface select registers
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [15:0] sm, br;
    logic [7:0] w8, mx;
    logic [15:0] eif, sm_rd, br_rd;
    logic [3:0] c0, c1;
    logic [5:0] w0, w1;
  } eaisr_row_type;

  // rows 1 to 3 leave conflicting selects set on purpose
  eaisr_row_type rows [5] = '{
    '{16'hFFFF, 16'h0000, 8'h00, 8'h00, 16'h5555, 16'hFF00, 16'h0000, 4'h1, 4'h1, 6'h04, 6'h04},
    '{16'hFF00, 16'hFFFF, 8'h0F, 8'hF8, 16'hFFCA, 16'hFF00, 16'hF3F3, 4'h8, 4'h8, 6'h20, 6'h20},
    '{16'hAA00, 16'h5252, 8'h80, 8'h07, 16'h0444, 16'hAA00, 16'h5252, 4'h6, 4'h6, 6'h10, 6'h10},
    '{16'h0300, 16'h8080, 8'h00, 8'h00, 16'h000A, 16'h0300, 16'h8080, 4'h1, 4'h1, 6'h04, 6'h04},
    '{16'h0000, 16'h2D2D, 8'hFF, 8'h00, 16'h0000, 16'h0000, 16'h2121, 4'h3, 4'h3, 6'h08, 6'h08}};

  logic clk, rst_n, ce, wr_stb, rd_stb, cfg_pending, ext_bus_busy, start, stall;
  logic [3:0] addr, a0_cyc, a1_cyc;
  logic [15:0] wr_data, rd_data, area_if_type, d;
  logic [7:0] area_8bit, area_muxed_sel;
  logic [5:0] a0_words, a1_words;
  int error_cnt = 0;
  int n_checks = 0;

  eaisr_regs DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .area_8bit(area_8bit),
    .area_muxed_sel(area_muxed_sel), .ext_bus_busy(ext_bus_busy),
    .area_if_type(area_if_type), .area0_burst_cycles(a0_cyc), .area0_burst_words(a0_words),
    .area1_burst_cycles(a1_cyc), .area1_burst_words(a1_words), .cfg_pending(cfg_pending));
  eaisr_seq_model seq (.clk(clk), .rst_n(rst_n), .start(start), .stall(stall),
    .cycles(a0_cyc), .ext_bus_busy(ext_bus_busy));

  // ==========================================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  task automatic settle();
    int i;
    i = 0;
    repeat (2) @(posedge clk);
    #1;
    while (cfg_pending !== 1'b0 && i < 20) begin
      @(posedge clk);
      #1;
      i++;
    end
  endtask : settle

  task automatic chk_out(input logic [15:0] eif, input logic [3:0] c0, input logic [3:0] c1,
                         input logic [5:0] w0, input logic [5:0] w1);
    chk(area_if_type, eif);
    chk(16'(a0_cyc), 16'(c0));
    chk(16'(a0_words), 16'(w0));
    chk(16'(a1_cyc), 16'(c1));
    chk(16'(a1_words), 16'(w1));
  endtask : chk_out

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================
  // clock, watchdog, sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #40000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    addr = 4'h0;
    wr_data = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    area_8bit = 8'h00;
    area_muxed_sel = 8'h00;
    start = 1'b0;
    stall = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      area_8bit <= rows[i].w8;
      area_muxed_sel <= rows[i].mx;
      wr(4'h0, rows[i].sm);
      wr(4'h2, rows[i].br);
      settle();
      chk(16'(cfg_pending), 16'h0000);
      chk_out(rows[i].eif, rows[i].c0, rows[i].c1, rows[i].w0, rows[i].w1);
      rd(4'h0);
      chk(d, rows[i].sm_rd);
      rd(4'h2);
      chk(d, rows[i].br_rd);
      $display("row %0d done", i);
    end
    // a change made mid-access must wait for the bus to go idle
    start <= 1'b1;
    stall <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    wr(4'h2, 16'h8000);
    repeat (6) @(posedge clk);
    #1;
    chk(16'(cfg_pending), 16'h0001);
    chk(16'(a0_cyc), 16'h0003);
    stall <= 1'b0;
    settle();
    chk_out(16'h0002, 4'h1, 4'h1, 6'h04, 6'h04);
    $display("busy hold done");
    rd(4'h4);
    chk(d, 16'h0002);
    @(posedge clk);
    #1;
    chk(rd_data, 16'h0000);
    wr(4'h4, 16'hFFFF);
    rd(4'h6);
    chk(d, 16'h0000);
    rd(4'h4);
    chk(d, 16'h0002);
    ce <= 1'b0;
    wr(4'h0, 16'hFF00);
    ce <= 1'b1;
    rd(4'h0);
    chk(d, 16'h0000);
    $display("bus edge cases done");
    wr(4'h0, 16'hFF00);
    area_8bit <= 8'h00;
    rst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'(cfg_pending), 16'h0000);
    chk_out(16'h0000, 4'h1, 4'h1, 6'h04, 6'h04);
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(4'h0);
    chk(d, 16'h0000);
    rd(4'h2);
    chk(d, 16'h0000);
    wr(4'h0, 16'h0100);
    settle();
    chk(area_if_type, 16'h0001);
    $display("reset done");
    end_of_test();
  end
endmodule : testbench
